// ### testbench/tb_timer_slave_mode_control.sv
// Self-checking bench for the timer slave-mode control block.
// Assumes the trig_source model drives channel and trigger inputs.
`default_nettype none

module tb_timer_slave_mode_control;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, pready, pslverr, e, in_one, in_two, trig;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        clr_in = 1'b0, ext_trg = 1'b0, moe = 1'b0;
  logic        step_go = 1'b0, step_back = 1'b0, trig_set = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, v;
  logic [6:0]  drive = 7'h00, out_level;
  logic [15:0] count_value, base;
  logic [1:0]  ph = 2'h0;
  logic        count_down, update_event, ref_clear_out;
  int          miscompares = 0, checks_done = 0, seed = 47391, i, m, k, mc;

  timer_slave_mode_control i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .filtered_input_one(in_one), .filtered_input_two(in_two), .trigger_input(trig),
    .compare_ref_clear_in(clr_in), .filtered_external_trigger(ext_trg),
    .main_output_enable(moe), .channel_drive(drive), .out_level(out_level),
    .count_value(count_value), .count_down(count_down), .update_event(update_event),
    .ref_clear_out(ref_clear_out));

  trig_source i_src (
    .pclk(pclk), .presetn(presetn), .step_go(step_go), .step_back(step_back),
    .trig_set(trig_set), .ch_one(in_one), .ch_two(in_two), .trig(trig));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic done(input string s);
    $display("test %0s done", s);
  endtask

  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  // One quadrature step; task predicts count and direction
  task automatic step(input logic b);
    logic [1:0] np;
    logic       c1, c2, eq;
    int         dn;
    step_back <= b;
    step_go <= 1'b1;
    @(posedge pclk);
    step_go <= 1'b0;
    np = b ? ph - 2'h1 : ph + 2'h1;
    c1 = (np[1] ^ np[0]) != (ph[1] ^ ph[0]);
    c2 = np[1] != ph[1];
    eq = !np[0];
    dn = -1;
    if (c1 && m != 1) dn = !eq;
    else if (c2 && m != 2) dn = eq;
    ph = np;
    cyc(3);
    if (dn >= 0) begin
      mc = (dn == 1) ? mc - 1 : mc + 1;
      chk(count_down, dn[0]);
    end
  endtask

  initial begin
    cyc(60000);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, 32'h0);
    chk(e, 1'b0);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h0);
    chk(e, 1'b1);
    v = $random(seed);
    wr(8'h08, v);
    rd(8'h08, v & 32'hF);
    wr(8'h08, 32'h0);
    done("map");
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(8'h04, v);
      rd(8'h04, v & 32'h7F00);
      moe <= 1'b0;
      cyc(2);
      chk(out_level, v[14:8]);
      moe <= 1'b1;
      drive <= v[22:16];
      cyc(2);
      chk(out_level, v[22:16]);
    end
    // Locked levels keep the last unlocked value
    for (i = 1; i < 4; i++) begin
      wr(8'h0C, i);
      wr(8'h04, ~v);
      rd(8'h04, v & 32'h7F00);
    end
    wr(8'h0C, 32'h0);
    done("idle");
    for (i = 0; i < 8; i++) begin
      if (i % 4 == 0) wr(8'h08, (i / 4) << 3);
      v = $random(seed);
      clr_in <= v[0];
      ext_trg <= v[1];
      cyc(2);
      chk(ref_clear_out, (i < 4) ? v[0] : v[1]);
    end
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    cyc(2);
    base = count_value;
    cyc(10);
    chk(count_value, 16'(base + 16'hA));
    wr(8'h00, 32'h0);
    cyc(2);
    base = count_value;
    cyc(5);
    chk(count_value, base);
    done("internal");
    wr(8'h00, 32'h1);
    for (m = 1; m < 4; m++) begin
      wr(8'h08, m);
      cyc(3);
      mc = count_value;
      repeat (10) begin
        v = $random(seed);
        step(v[0]);
      end
      chk(count_value, 16'(mc));
    end
    done("encoder");
    wr(8'h08, 32'h4);
    cyc(4);
    trig_set <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (update_event !== 1'b1 && k < 8);
    chk(k < 8, 1'b1);
    if (k >= 8) report_and_stop();
    chk(count_value, 32'h0);
    @(posedge pclk);
    chk(update_event, 1'b0);
    trig_set <= 1'b0;
    wr(8'h08, 32'h5);
    cyc(3);
    base = count_value;
    cyc(6);
    chk(count_value, base);
    trig_set <= 1'b1;
    cyc(4);
    base = count_value;
    cyc(8);
    chk(count_value, 16'(base + 16'h8));
    trig_set <= 1'b0;
    cyc(4);
    base = count_value;
    cyc(5);
    chk(count_value, base);
    trig_set <= 1'b1;
    cyc(3);
    chk(count_value, 16'(base + 16'h1));
    trig_set <= 1'b0;
    done("reset_gated");
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h6);
    cyc(3);
    base = count_value;
    cyc(5);
    chk(count_value, base);
    trig_set <= 1'b1;
    cyc(4);
    trig_set <= 1'b0;
    rd(8'h00, 32'h1);
    chk(count_value != base, 1'b1);
    wr(8'h08, 32'h7);
    cyc(3);
    base = count_value;
    v = $random(seed);
    for (i = 0; i <= v[2:0]; i++) begin
      trig_set <= 1'b1;
      cyc(2);
      trig_set <= 1'b0;
      cyc(2);
    end
    cyc(3);
    chk(count_value, 16'(base + v[2:0] + 16'h1));
    done("trigger_extclk");
    report_and_stop();
  end
endmodule // tb_timer_slave_mode_control

`default_nettype wire

// ### testbench/trig_source.sv
// Far-side model: quadrature channel pair and trigger level of a master timer.
// Assumes one command per cycle from the bench, on the rising edge of pclk.
`default_nettype none

module trig_source (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Commands
  input  wire logic step_go,
  input  wire logic step_back,
  input  wire logic trig_set,
  // Timer inputs
  output logic      ch_one,
  output logic      ch_two,
  output logic      trig
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] phase_reg;
  logic       trig_reg;

  // Gray order: only one channel moves per step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 2'h0;
    end else if (step_go) begin
      phase_reg <= step_back ? phase_reg - 2'h1 : phase_reg + 2'h1;
    end
  end

  // Level moves only on command, low whenever the bench reselects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= trig_set;
    end
  end

  assign ch_one = phase_reg[1] ^ phase_reg[0];
  assign ch_two = phase_reg[1];
  assign trig   = trig_reg;
endmodule // trig_source

`default_nettype wire

// ### verilog/count_step.sv
// Per-cycle count step and direction for each slave function.
// Assumes all inputs are synchronous to the kernel clock.
`default_nettype none

module count_step (
  // Configuration
  input  wire logic [2:0] mode,
  input  wire logic       run,
  // Current and previous input levels
  input  wire logic       in_one,
  input  wire logic       in_two,
  input  wire logic       one_prev,
  input  wire logic       two_prev,
  input  wire logic       trig,
  input  wire logic       trig_rise,
  // Result
  output logic            step,
  output logic            down
);

  logic edge_one;
  logic edge_two;

  assign edge_one = in_one ^ one_prev;
  assign edge_two = in_two ^ two_prev;

  always_comb begin
    step = 1'b0;
    down = 1'b0;
    case (mode)
      timer_slave_pkg::MODE_OFF: begin
        step = run;
      end
      timer_slave_pkg::MODE_ENC1: begin
        step = run & edge_two;
        down = ~(in_one ^ in_two);
      end
      timer_slave_pkg::MODE_ENC2: begin
        step = run & edge_one;
        down = in_one ^ in_two;
      end
      timer_slave_pkg::MODE_ENC3: begin
        step = run & (edge_one | edge_two);
        down = edge_one ? (in_one ^ in_two) : ~(in_one ^ in_two);
      end
      timer_slave_pkg::MODE_GATED: begin
        step = run & trig;
      end
      timer_slave_pkg::MODE_EXTCLK: begin
        step = run & trig_rise;
      end
      default: begin
        step = run;
      end
    endcase
  end

endmodule // count_step

`default_nettype wire

// ### verilog/timer_slave_mode_control.sv
// Slave-mode control of a timer: mode decode, 16-bit counter, idle levels, APB registers.
// Assumes synchronous channel and trigger inputs and a 32-bit APB master on pclk.
//
// How it works
// - Mode 000: no slave function, counter ticks each clock while run bit set.
// - Mode 001: count on channel two edges, direction from channel one level.
// - Mode 010: count on channel one edges, direction from channel two level.
// - Mode 011: count on edges of both channels, each qualified by the other.
// - Mode 100: trigger rising edge clears counter and pulses an update.
// - Mode 101: counter runs while trigger high, pauses while low, never cleared.
// - Mode 110: trigger rising edge starts the counter.
// - Mode 111: each trigger rising edge advances the counter once.
// - Bit 3 picks the reference clear source: clear input or external trigger.
// - Control-two bits 11 and 13 are complementary idle levels of channels 2, 3.
// - Control-two bits 12 and 14 are main idle levels of channels 3, 4.
// - Slave mode register sits at 0x08 and resets to zero.
// - With main output enable low, each output shows its idle level.
// - Idle bits ignore writes while the break lock level is nonzero.
//
// Implementation choice: the APB slave port.
`default_nettype none

module timer_slave_mode_control (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Timer inputs
  input  wire logic        filtered_input_one,
  input  wire logic        filtered_input_two,
  input  wire logic        trigger_input,
  input  wire logic        compare_ref_clear_in,
  input  wire logic        filtered_external_trigger,
  // Output stage
  input  wire logic        main_output_enable,
  input  wire logic [6:0]  channel_drive,
  output logic [6:0]       out_level,
  // Counter state
  output logic [15:0]      count_value,
  output logic             count_down,
  output logic             update_event,
  output logic             ref_clear_out
);

  timer_slave_pkg::slave_mode_t   mode_reg;
  timer_slave_pkg::apb_resp_t     resp_reg;
  timer_slave_pkg::apb_resp_t     resp_next;
  logic                           run_reg;
  logic [6:0]                     idle_reg;
  logic [1:0]                     lock_reg;
  logic [15:0]                    count_reg;
  logic                           down_reg;
  logic                           update_reg;
  logic                           refclr_reg;
  logic [6:0]                     out_reg;
  logic                           one_prev_reg;
  logic                           two_prev_reg;
  logic                           trig_prev_reg;
  logic                           trig_rise;
  logic                           step;
  logic                           step_down;
  logic                           wr_en;
  logic                           rd_setup;
  logic [2:0]                     mode;

  assign mode      = mode_reg.slave_function_select;
  assign trig_rise = trigger_input & ~trig_prev_reg;
  // Access finishes on the edge that sees our registered ready
  assign wr_en     = psel & penable & pwrite & resp_reg.ready;
  assign rd_setup  = psel & penable & ~resp_reg.ready;

  // APB response: one wait state, then ready with data
  always_comb begin
    resp_next = '0;
    if (rd_setup) begin
      resp_next.ready = 1'b1;
      case (paddr)
        timer_slave_pkg::OFF_CTRL_ONE: begin
          resp_next.data[timer_slave_pkg::RUN_BIT] = run_reg;
        end
        timer_slave_pkg::OFF_CTRL_TWO: begin
          // Bit 15 and unmodelled bits stay zero
          resp_next.data[timer_slave_pkg::IDLE_LSB +: timer_slave_pkg::IDLE_BITS] =
            idle_reg;
        end
        timer_slave_pkg::OFF_SLAVE_MODE: begin
          resp_next.data[15:0] = mode_reg;
        end
        timer_slave_pkg::OFF_LOCK: begin
          resp_next.data[timer_slave_pkg::LOCK_LSB +: 2] = lock_reg;
        end
        timer_slave_pkg::OFF_COUNT: begin
          resp_next.data[15:0] = count_reg;
        end
        default: begin
          resp_next.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_reg <= '0;
    end else begin
      resp_reg <= resp_next;
    end
  end

  // Slave mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= timer_slave_pkg::SLAVE_MODE_RESET;
    end else if (wr_en && paddr == timer_slave_pkg::OFF_SLAVE_MODE) begin
      mode_reg.slave_function_select   <= pwdata[timer_slave_pkg::MODE_LSB +: 3];
      mode_reg.ref_clear_source_select <= pwdata[timer_slave_pkg::REFSEL_BIT];
    end
  end

  // Run bit: a trigger start wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
    end else if (mode == timer_slave_pkg::MODE_TRIGGER && trig_rise) begin
      run_reg <= 1'b1;
    end else if (wr_en && paddr == timer_slave_pkg::OFF_CTRL_ONE) begin
      run_reg <= pwdata[timer_slave_pkg::RUN_BIT];
    end
  end

  // Idle levels, frozen under any nonzero lock level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_reg <= timer_slave_pkg::IDLE_RESET;
    end else if (wr_en && paddr == timer_slave_pkg::OFF_CTRL_TWO
                 && lock_reg == 2'h0) begin
      idle_reg <=
        pwdata[timer_slave_pkg::IDLE_LSB +: timer_slave_pkg::IDLE_BITS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= timer_slave_pkg::LOCK_RESET;
    end else if (wr_en && paddr == timer_slave_pkg::OFF_LOCK) begin
      lock_reg <= pwdata[timer_slave_pkg::LOCK_LSB +: 2];
    end
  end

  // Previous levels; trigger edges are only valid if the source was
  // switched while the slave function was off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_prev_reg  <= 1'b0;
      two_prev_reg  <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      one_prev_reg  <= filtered_input_one;
      two_prev_reg  <= filtered_input_two;
      trig_prev_reg <= trigger_input;
    end
  end

  count_step u_step (
    .mode      (mode),
    .run       (run_reg),
    .in_one    (filtered_input_one),
    .in_two    (filtered_input_two),
    .one_prev  (one_prev_reg),
    .two_prev  (two_prev_reg),
    .trig      (trigger_input),
    .trig_rise (trig_rise),
    .step      (step),
    .down      (step_down)
  );

  // Counter; reset-mode clear has priority over a step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= timer_slave_pkg::COUNT_RESET;
      down_reg  <= 1'b0;
    end else if (mode == timer_slave_pkg::MODE_RESET && trig_rise) begin
      count_reg <= timer_slave_pkg::COUNT_RESET;
    end else if (step) begin
      count_reg <= step_down ? 16'(count_reg - 16'h0001) : 16'(count_reg + 16'h0001);
      down_reg  <= step_down;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_reg <= 1'b0;
    end else begin
      update_reg <= (mode == timer_slave_pkg::MODE_RESET) & trig_rise;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refclr_reg <= 1'b0;
    end else begin
      refclr_reg <= mode_reg.ref_clear_source_select ? filtered_external_trigger
                                                     : compare_ref_clear_in;
    end
  end

  // Output stage: idle level replaces the active drive when outputs are off
  for (genvar i = 0; i < timer_slave_pkg::IDLE_BITS; i++) begin : g_out
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_reg[i] <= 1'b0;
      end else begin
        out_reg[i] <= main_output_enable ? channel_drive[i] : idle_reg[i];
      end
    end
  end

  assign pready        = resp_reg.ready;
  assign pslverr       = resp_reg.err;
  assign prdata        = resp_reg.data;
  assign out_level     = out_reg;
  assign count_value   = count_reg;
  assign count_down    = down_reg;
  assign update_event  = update_reg;
  assign ref_clear_out = refclr_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_off_ticks: assert property (
    (mode == timer_slave_pkg::MODE_OFF && run_reg) |=>
      count_reg == 16'($past(count_reg) + 16'h0001))
    else $error("Counter did not tick in internal clock mode");

  chk_enc1_steps: assert property (
    (mode == timer_slave_pkg::MODE_ENC1 && run_reg) |=>
      ((count_reg != $past(count_reg)) == $past(filtered_input_two != two_prev_reg)))
    else $error("Encoder mode 1 step mismatch");

  chk_enc2_steps: assert property (
    (mode == timer_slave_pkg::MODE_ENC2 && run_reg && filtered_input_one != one_prev_reg)
      |=> count_reg != $past(count_reg))
    else $error("Encoder mode 2 missed an edge");

  chk_enc2_hold: assert property (
    (mode == timer_slave_pkg::MODE_ENC2 && filtered_input_one == one_prev_reg)
      |=> $stable(count_reg))
    else $error("Encoder mode 2 counted without an edge");

  chk_enc3_steps: assert property (
    (mode == timer_slave_pkg::MODE_ENC3 && run_reg &&
     (filtered_input_one != one_prev_reg || filtered_input_two != two_prev_reg))
      |=> count_reg != $past(count_reg))
    else $error("Encoder mode 3 missed an edge");

  chk_reset_clears: assert property (
    (mode == timer_slave_pkg::MODE_RESET && trig_rise) |=>
      (count_reg == 16'h0000 && update_event) ##1 !update_event)
    else $error("Reset mode did not clear and update");

  chk_gated_pause: assert property (
    (mode == timer_slave_pkg::MODE_GATED && !trigger_input) |=> $stable(count_reg))
    else $error("Gated mode counted with trigger low");

  chk_trigger_start: assert property (
    (mode == timer_slave_pkg::MODE_TRIGGER && trig_rise) |=>
      run_reg ##1 count_reg != $past(count_reg))
    else $error("Trigger mode did not start the counter");

  chk_extclk_hold: assert property (
    (mode == timer_slave_pkg::MODE_EXTCLK && !trig_rise) |=> $stable(count_reg))
    else $error("External clock mode counted without a trigger edge");

  chk_ref_clear_sel: assert property (
    1'b1 |=> ref_clear_out == ($past(mode_reg.ref_clear_source_select)
                               ? $past(filtered_external_trigger) : $past(compare_ref_clear_in)))
    else $error("Reference clear source mismatch");

  chk_idle_level: assert property (
    !main_output_enable |=> out_level == $past(idle_reg))
    else $error("Idle level not driven while outputs disabled");

  chk_lock_keeps: assert property (
    (wr_en && paddr == timer_slave_pkg::OFF_CTRL_TWO && lock_reg != 2'h0) |=> $stable(idle_reg))
    else $error("Idle bits changed while locked");

  chk_reserved_zero: assert property (
    (rd_setup && paddr == timer_slave_pkg::OFF_CTRL_TWO) |=> pready && prdata[15] == 1'b0)
    else $error("Reserved bit 15 read as one");

  cov_enc3_step: cover property (mode == timer_slave_pkg::MODE_ENC3 && step);
  cov_reset_event: cover property (update_event);
  cov_trigger_start: cover property (
    mode == timer_slave_pkg::MODE_TRIGGER && trig_rise && !run_reg);
  cov_gated_resume: cover property (mode == timer_slave_pkg::MODE_GATED && run_reg && trig_rise);

endmodule // timer_slave_mode_control

`default_nettype wire

// ### verilog/timer_slave_pkg.sv
// Constants and carriers for the timer slave-mode control block.
// Assumes a 32-bit APB master and byte addresses on word boundaries.
`default_nettype none

package timer_slave_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO   = 8'h04;
  localparam logic [7:0] OFF_SLAVE_MODE = 8'h08;
  localparam logic [7:0] OFF_LOCK       = 8'h0C;
  localparam logic [7:0] OFF_COUNT      = 8'h10;

  // Field positions
  localparam int RUN_BIT     = 0;
  localparam int MODE_LSB    = 0;
  localparam int REFSEL_BIT  = 3;
  localparam int IDLE_LSB    = 8;
  localparam int IDLE_BITS   = 7;
  localparam int LOCK_LSB    = 0;

  // Reset values
  localparam logic [15:0] SLAVE_MODE_RESET = 16'h0000;
  localparam logic [6:0]  IDLE_RESET       = 7'h00;
  localparam logic [1:0]  LOCK_RESET       = 2'h0;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;

  // Slave function codes
  localparam logic [2:0] MODE_OFF     = 3'h0;
  localparam logic [2:0] MODE_ENC1    = 3'h1;
  localparam logic [2:0] MODE_ENC2    = 3'h2;
  localparam logic [2:0] MODE_ENC3    = 3'h3;
  localparam logic [2:0] MODE_RESET   = 3'h4;
  localparam logic [2:0] MODE_GATED   = 3'h5;
  localparam logic [2:0] MODE_TRIGGER = 3'h6;
  localparam logic [2:0] MODE_EXTCLK  = 3'h7;

  typedef struct packed {
    logic [11:0] unused;
    logic        ref_clear_source_select;
    logic [2:0]  slave_function_select;
  } slave_mode_t;

  typedef struct packed {
    logic        ready;
    logic        err;
    logic [31:0] data;
  } apb_resp_t;

endpackage

`default_nettype wire
